// *** logic/ihpd_consts.svh ***
`ifndef IHPD_CONSTS_SVH
`define IHPD_CONSTS_SVH
`define IHPD_REG_DATA 3'h0
`define IHPD_REG_ERRFEAT 3'h1
`define IHPD_REG_STATUS 3'h7
`define IHPD_CTL_ALTSTAT 3'h6
`define IHPD_NREGS 8
`define IHPD_BYTE_W 8
`define IHPD_WORD_W 16
`define IHPD_ZERO_BYTE 8'h00
`define IHPD_ZERO_WORD 16'h0000
`define IHPD_SYNC_IDLE 2'h3
`endif

// *** logic/ihpd_pkg.sv ***
package ihpd_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} ihpd_state_e;
	typedef struct packed {
		logic [1:0] sync_a;
		logic [1:0] sync_b;
	} ihpd_sync_s;
endpackage

// *** logic/ihpd_sync.sv ***
`timescale 1ns/1ps
`include "ihpd_consts.svh"
// two-flop synchroniser for one level
module ihpd_sync
	import ihpd_pkg::*;
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	// level in and out
	input wire logic i_level,
	output logic o_level
);
	logic [1:0] st_q;
	logic [1:0] st_d;
	always_comb
	begin
		st_d = {st_q[0], i_level};
	end
	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			st_q <= `IHPD_SYNC_IDLE;
		else
			st_q <= st_d;
	end
	assign o_level = st_q[1];
endmodule

// *** logic/ihpd_port.sv ***
`timescale 1ns/1ps
`include "ihpd_consts.svh"
// How it works
// - only address bits 2:0 select one of eight registers
// - first select reaches task file, second reaches alt status/control
// - task file bytes travel on data bits 7:0 only
// - data register moves one sixteen-bit word per strobe
// - write data taken on rising edge of write strobe
// - interrupt request driven active high
// - active-low reset returns port logic to initial state
// - word-transfer indicator low only for data register access
// - pass-diagnostic pin is bidirectional in handshake
// - active/slave-present pin is bidirectional in handshake
// - status read clears interrupt, alternate status read does not
module ihpd_port
	import ihpd_pkg::*;
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	// host address and selects
	input wire logic [2:0] i_addr,
	input wire logic i_cs0_n,
	input wire logic i_cs1_n,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	// host data bus
	input wire logic [15:0] i_data,
	output logic [15:0] o_data,
	output logic o_data_oe_n,
	// host status pins
	output logic o_intrq,
	output logic o_iocs16_n,
	output logic o_iordy,
	// master/slave handshake pins
	input wire logic i_pdiag_n,
	output logic o_pdiag_n,
	output logic o_pdiag_oe_n,
	input wire logic i_dasp_n,
	output logic o_dasp_n,
	output logic o_dasp_oe_n,
	// core side
	input wire logic [7:0] i_reg_rdata [`IHPD_NREGS],
	input wire logic [7:0] i_ctl_rdata,
	input wire logic [15:0] i_word_rdata,
	input wire logic i_irq_event,
	input wire logic i_pdiag_drive,
	input wire logic i_dasp_drive,
	output logic o_wr_pulse,
	output logic o_wr_ctl,
	output logic [2:0] o_wr_addr,
	output logic [15:0] o_wr_data,
	output logic o_rd_word_pulse,
	output logic o_pdiag_seen,
	output logic o_dasp_seen
);
	typedef struct packed {
		ihpd_state_e state;
		logic intrq;
		logic [15:0] rdata;
		logic drive;
		logic wr_pulse;
		logic wr_ctl;
		logic [2:0] wr_addr;
		logic [15:0] wr_data;
		logic rd_word;
		logic [2:0] addr_s;
		logic cs0_s;
		logic cs1_s;
		logic [15:0] data_s;
	} ihpd_port_s;

	ihpd_port_s s_q;
	ihpd_port_s s_d;
	logic rd_s;
	logic wr_s;
	logic cs0_sy;
	logic cs1_sy;
	logic pdiag_sy;
	logic dasp_sy;

	function automatic logic is_data_reg(input logic cs0, input logic cs1, input logic [2:0] a);
		is_data_reg = !cs0 && cs1 && (a == `IHPD_REG_DATA);
	endfunction

	// strobe, select and handshake pin sync
	ihpd_sync u_rd (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_level(i_rd_n), .o_level(rd_s));
	ihpd_sync u_wr (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_level(i_wr_n), .o_level(wr_s));
	ihpd_sync u_c0 (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_level(i_cs0_n),
		.o_level(cs0_sy));
	ihpd_sync u_c1 (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_level(i_cs1_n),
		.o_level(cs1_sy));
	ihpd_sync u_pd (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_level(i_pdiag_n),
		.o_level(pdiag_sy));
	ihpd_sync u_da (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_level(i_dasp_n),
		.o_level(dasp_sy));

	always_comb
	begin
		s_d = s_q;
		s_d.wr_pulse = 1'b0;
		s_d.rd_word = 1'b0;
		// address and data held stable by host around strobes; latch address and selects while idle, data while write strobe low
		if (s_q.state == ST_IDLE)
		begin
			s_d.addr_s = i_addr;
			s_d.cs0_s = cs0_sy;
			s_d.cs1_s = cs1_sy;
		end
		if (!wr_s)
			s_d.data_s = i_data;
		unique case (s_q.state)
			ST_IDLE:
			begin
				if (!rd_s && (!cs0_sy || !cs1_sy))
				begin
					s_d.state = ST_READ;
					s_d.drive = 1'b1;
					if (is_data_reg(cs0_sy, cs1_sy, i_addr))
						s_d.rdata = i_word_rdata;
					else if (!cs0_sy)
						s_d.rdata = {`IHPD_ZERO_BYTE, i_reg_rdata[i_addr]};
					else if (i_addr == `IHPD_CTL_ALTSTAT)
						s_d.rdata = {`IHPD_ZERO_BYTE, i_ctl_rdata};
					else
						s_d.rdata = `IHPD_ZERO_WORD;
				end
				else if (!wr_s && (!cs0_sy || !cs1_sy))
					s_d.state = ST_WRITE;
			end
			ST_READ:
			begin
				if (rd_s)
				begin
					s_d.state = ST_IDLE;
					s_d.drive = 1'b0;
					if (is_data_reg(s_q.cs0_s, s_q.cs1_s, s_q.addr_s))
						s_d.rd_word = 1'b1;
					if (!s_q.cs0_s && s_q.addr_s == `IHPD_REG_STATUS)
						s_d.intrq = 1'b0;
				end
			end
			ST_WRITE:
			begin
				if (wr_s)
				begin
					s_d.state = ST_IDLE;
					s_d.wr_pulse = 1'b1;
					s_d.wr_ctl = s_q.cs0_s;
					s_d.wr_addr = s_q.addr_s;
					if (is_data_reg(s_q.cs0_s, s_q.cs1_s, s_q.addr_s))
						s_d.wr_data = s_q.data_s;
					else
						s_d.wr_data = {`IHPD_ZERO_BYTE, s_q.data_s[7:0]};
				end
			end
		endcase
		if (i_irq_event)
			s_d.intrq = 1'b1;
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			s_q <= '{state: ST_IDLE, cs0_s: 1'b1, cs1_s: 1'b1, default: '0};
		else
			s_q <= s_d;
	end

	assign o_data = s_q.rdata;
	assign o_data_oe_n = !s_q.drive;
	assign o_intrq = s_q.intrq;
	assign o_iocs16_n = !is_data_reg(cs0_sy, cs1_sy, i_addr);
	assign o_iordy = 1'b1;
	assign o_pdiag_n = 1'b0;
	assign o_pdiag_oe_n = !i_pdiag_drive;
	assign o_pdiag_seen = !pdiag_sy;
	assign o_dasp_n = 1'b0;
	assign o_dasp_oe_n = !i_dasp_drive;
	assign o_dasp_seen = !dasp_sy;
	assign o_wr_pulse = s_q.wr_pulse;
	assign o_wr_ctl = s_q.wr_ctl;
	assign o_wr_addr = s_q.wr_addr;
	assign o_wr_data = s_q.wr_data;
	assign o_rd_word_pulse = s_q.rd_word;
endmodule

// *** verification/ihpd_port_monitor.sv ***
`timescale 1ns/1ps
module ihpd_port_monitor (
	// host pins and results
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic [2:0] i_addr,
	input wire logic i_cs0_n,
	input wire logic i_cs1_n,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic o_data_oe_n,
	input wire logic o_intrq,
	input wire logic o_iocs16_n,
	input wire logic o_wr_pulse
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);
	a_wr_on_rise: assert property ($rose(i_wr_n) && !i_cs0_n |-> ##[1:4] o_wr_pulse)
		else $error("no write");
	a_wr_strobe_up: assert property (o_wr_pulse |-> i_wr_n && $past(i_wr_n))
		else $error("early write");
	a_rd_drive: assert property ($fell(i_rd_n) && !i_cs0_n |-> ##[1:4] !o_data_oe_n)
		else $error("no drive");
	a_rd_release: assert property (i_rd_n [*5] |-> o_data_oe_n)
		else $error("bus held");
	a_word_on: assert property ((!i_cs0_n && i_cs1_n && i_addr == 3'h0)[*3] |-> !o_iocs16_n)
		else $error("word off");
	a_word_off: assert property (i_addr != 3'h0 |-> o_iocs16_n)
		else $error("word on");
	a_irq_clear: assert property ($rose(i_rd_n) && !i_cs0_n && i_addr == 3'h7 |-> ##[1:4] !o_intrq)
		else $error("irq kept");
	a_irq_keep: assert property ($rose(i_rd_n) && !i_cs1_n && o_intrq |=> o_intrq [*4])
		else $error("irq lost");
endmodule

// *** verification/ihpd_host.sv ***
`timescale 1ns/1ps
module ihpd_host (
	// clock and device read data
	input wire logic i_ref_clk,
	input wire logic [15:0] i_rdata,
	// host bus pins
	output logic [2:0] o_addr,
	output logic o_cs0_n,
	output logic o_cs1_n,
	output logic o_rd_n,
	output logic o_wr_n,
	output logic [15:0] o_wdata
);
	initial {o_addr, o_cs1_n, o_cs0_n, o_rd_n, o_wr_n, o_wdata} = 23'h0f0000;
	// one access: strobe low 4 cycles, then high 4 cycles, selects held throughout
	task automatic acc(input logic w, input logic [4:0] sel, input logic [15:0] d,
		output logic [15:0] q);
		@(posedge i_ref_clk) #1;
		{o_cs1_n, o_cs0_n, o_addr} = sel;
		o_wdata = d;
		@(posedge i_ref_clk) #1;
		o_wr_n = !w;
		o_rd_n = w;
		repeat (4) @(posedge i_ref_clk);
		q = i_rdata;
		#1 {o_rd_n, o_wr_n} = 2'b11;
		repeat (4) @(posedge i_ref_clk);
		#1 {o_cs1_n, o_cs0_n} = 2'b11;
		o_wdata = ~o_wdata;
	endtask
endmodule

// *** verification/ihpd_port_test.sv ***
`timescale 1ns/1ps
module ihpd_port_test;
	logic i_ref_clk, i_nrst, i_cs0_n, i_cs1_n, i_rd_n, i_wr_n, i_irq_event, o_wr_ctl;
	logic [2:0] i_addr, o_wr_addr;
	logic [15:0] i_data, o_data, i_word_rdata, o_wr_data, wdat, q;
	logic [7:0] i_reg_rdata [8];
	logic [7:0] i_ctl_rdata;
	logic o_data_oe_n, o_intrq, o_iocs16_n, o_iordy, i_pdiag_n, o_pdiag_n, o_pdiag_oe_n;
	logic i_dasp_n, o_dasp_n, o_dasp_oe_n, i_pdiag_drive, i_dasp_drive, o_wr_pulse;
	logic o_rd_word_pulse, o_pdiag_seen, o_dasp_seen, pd_ext;
	logic [3:0] wsel;
	int err_count, samples_checked, rdw;
	ihpd_port i_dut (.*);
	// released data bus shows the inverse of the last word, so an undriven read fails
	ihpd_host i_host (.i_ref_clk(i_ref_clk), .i_rdata(o_data_oe_n ? ~o_data : o_data),
		.o_addr(i_addr),
		.o_cs0_n(i_cs0_n), .o_cs1_n(i_cs1_n), .o_rd_n(i_rd_n), .o_wr_n(i_wr_n), .o_wdata(i_data));
	// shared pins: far device pulls up unless driving
	assign i_pdiag_n = o_pdiag_oe_n ? pd_ext : o_pdiag_n;
	assign i_dasp_n = o_dasp_oe_n | o_dasp_n;
	always @(posedge i_ref_clk)
		if (o_wr_pulse)
			{wsel, wdat} <= {o_wr_ctl, o_wr_addr, o_wr_data};
	always @(posedge i_ref_clk)
		if (o_rd_word_pulse)
			rdw++;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic t_wr;
		i_host.acc(1, 5'h10, 16'hbeef, q);
		chk(wdat, 16'hbeef);
		i_host.acc(1, 5'h13, 16'ha55a, q);
		chk(wdat, 16'h005a);
		chk({12'h0, wsel}, 16'h3);
		i_host.acc(1, 5'h0e, 16'h0012, q);
		chk({12'h0, wsel}, 16'he);
		$display("write done");
	endtask
	task automatic t_rd;
		i_host.acc(0, 5'h10, 16'h0, q);
		chk(q, 16'h1234);
		chk(16'(rdw), 16'h1);
		i_host.acc(0, 5'h13, 16'h0, q);
		chk(q, 16'h0033);
		i_host.acc(0, 5'h0e, 16'h0, q);
		chk(q, 16'h005a);
		chk(16'(rdw), 16'h1);
		$display("read done");
	endtask
	task automatic t_irq;
		i_irq_event = 1;
		@(posedge i_ref_clk) #1;
		i_irq_event = 0;
		i_host.acc(0, 5'h0e, 16'h0, q);
		chk({15'h0, o_intrq}, 16'h1);
		i_host.acc(0, 5'h17, 16'h0, q);
		chk({15'h0, o_intrq}, 16'h0);
		i_irq_event = 1;
		@(posedge i_ref_clk) #1;
		i_nrst = 0;
		i_irq_event = 0;
		@(posedge i_ref_clk) #1;
		chk({15'h0, o_intrq}, 16'h0);
		i_nrst = 1;
		$display("irq done");
	endtask
	task automatic t_pin;
		pd_ext = 0;
		i_dasp_drive = 1;
		repeat (4) @(posedge i_ref_clk);
		chk({14'h0, o_pdiag_seen, o_pdiag_oe_n}, 16'h3);
		chk({14'h0, o_dasp_seen, o_dasp_oe_n}, 16'h2);
		$display("pin done");
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		i_ref_clk = 0;
		forever #4 i_ref_clk = ~i_ref_clk;
	end
	initial
	begin
		#100000;
		err_count++;
		print_verdict();
	end
	initial
	begin
		{i_nrst, i_irq_event, i_pdiag_drive, i_dasp_drive, pd_ext} = 5'h01;
		foreach (i_reg_rdata[i])
			i_reg_rdata[i] = 8'h30 + 8'(i);
		i_ctl_rdata = 8'h5a;
		i_word_rdata = 16'h1234;
		repeat (8) @(posedge i_ref_clk);
		#1 i_nrst = 1;
		t_wr();
		t_rd();
		t_irq();
		t_pin();
		print_verdict();
	end
endmodule
bind ihpd_port ihpd_port_monitor i_mon (.*);
